// ==== bench/lsci_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Register-bus host: one write and one read at a time, answers awaited up to 300 cycles.
module lsci_host_model (
  // Clock.
  input wire logic sys_clk,
  // Write channels.
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels.
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Set when an answer never came.
  logic hung;
  // Cycles before the response ready rises, to play a slow host.
  int lag;

  // Idle bus from time zero.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready, hung} = '0;
    lag = 0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    while (n < 300) begin
      @(posedge sys_clk);
      // Each channel is released only at the edge that takes it.
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
      if (n >= lag) s_axi_bready <= 1'b1;
      n++;
    end
    hung = 1'b1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (n < 300) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
      if (n >= lag) s_axi_rready <= 1'b1;
      n++;
    end
    hung = 1'b1;
  endtask : rd
endmodule : lsci_host_model
`default_nettype wire

// ==== bench/lsci_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsci_top_tb;
  import lsci_pkg::*;
  // Short full-resolution count keeps the run brief.
  localparam int FULL = 200;
  logic sys_clk, resetn, light_pulse;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, d0;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic int_pin_o, int_pin_oe, irq;
  wire int_line;
  int errors, compares;
  // The interrupt line has a pull-up; the device only sinks it.
  assign int_line = int_pin_oe ? int_pin_o : 1'b1;

  lsci_top #(.CONV_FULL_CYC(FULL)) i_lsci_top (.sys_clk(sys_clk),
    .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .light_pulse(light_pulse),
    .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .irq(irq));

  lsci_host_model i_lsci_host_model (.sys_clk(sys_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // Free-running 125 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bus write with an expected response code.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic [1:0] r;
    i_lsci_host_model.wr(a, v, r);
    if (i_lsci_host_model.hung) begin
      errors++;
      end_sim();
    end
    chk({30'h0, r}, {30'h0, er});
  endtask : wr

  // Bus read with an expected response code.
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic [1:0] r;
    i_lsci_host_model.rd(a, d, r);
    if (i_lsci_host_model.hung) begin
      errors++;
      end_sim();
    end
    chk({30'h0, r}, {30'h0, er});
  endtask : rd

  // Control word: mode, lux scale, full resolution, start.
  function automatic logic [31:0] cw(input logic [1:0] m,
                                     input logic [1:0] s, input logic g);
    return {25'h0, g, 2'b00, s, m};
  endfunction : cw

  // Bounded wait for the pin driver to reach a level.
  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (int_pin_oe !== lvl) begin
      @(posedge sys_clk);
      n++;
      if (n > 6000) begin
        errors++;
        end_sim();
      end
    end
  endtask : wait_oe

  // Reset state of pin, interrupt and registers.
  task automatic t_reset();
    chk({30'h0, int_pin_oe, irq}, 32'h0);
    chk({31'h0, int_line}, 32'h1);
    rd(LSCI_OFF_CTRL, LSCI_RESP_OKAY);
    chk(d, LSCI_CTRL_RST);
    rd(LSCI_OFF_STAT, LSCI_RESP_OKAY);
    chk(d, 32'h0);
  endtask : t_reset

  // One conversion, sticky flag, clear by status read, then silence.
  task automatic t_one_shot();
    wr(LSCI_OFF_CTRL, cw(2'b01, 2'b00, 1'b1), LSCI_RESP_OKAY);
    rd(LSCI_OFF_CTRL, LSCI_RESP_OKAY);
    chk(d, cw(2'b01, 2'b00, 1'b0));
    wait_oe(1'b1);
    chk({31'h0, int_line}, 32'h0);
    repeat (40) @(posedge sys_clk);
    chk({31'h0, int_pin_oe}, 32'h1);
    rd(LSCI_OFF_STAT, LSCI_RESP_OKAY);
    chk(d & 32'h5, 32'h1);
    @(posedge sys_clk);
    chk({31'h0, int_line}, 32'h1);
    rd(LSCI_OFF_DATA, LSCI_RESP_OKAY);
    chk(d >> 16, 32'h0);
    d0 = d;
    chk({31'h0, d0 != 0}, 32'h1);
    // One pulse per cycle over the shortest period counts that period.
    chk(d0, 32'(LSCI_CONV_MIN_CYC));
    repeat (3000) @(posedge sys_clk);
    chk({31'h0, int_pin_oe}, 32'h0);
  endtask : t_one_shot

  // Each higher scale gives a quarter of the counts of the one below.
  task automatic t_scales();
    logic [31:0] e;
    for (int s = 1; s < 4; s++) begin
      wr(LSCI_OFF_CTRL, cw(2'b01, s[1:0], 1'b1), LSCI_RESP_OKAY);
      wait_oe(1'b1);
      rd(LSCI_OFF_STAT, LSCI_RESP_OKAY);
      rd(LSCI_OFF_DATA, LSCI_RESP_OKAY);
      e = d0 >> (2 * s);
      chk({31'h0, d + 1 >= e && d <= e + 1}, 32'h1);
    end
  endtask : t_scales

  // Continuous run keeps updating under a pending flag; then power down.
  task automatic t_continuous();
    int n;
    i_lsci_host_model.lag = 3;
    wr(LSCI_OFF_CTRL, cw(2'b10, LSCI_LUX_SCALE_LOWEST, 1'b0),
       LSCI_RESP_OKAY);
    wait_oe(1'b1);
    light_pulse <= 1'b0;
    n = 0;
    d = 32'h1;
    while (d != 0 && n < 100) begin
      repeat (50) @(posedge sys_clk);
      rd(LSCI_OFF_DATA, LSCI_RESP_OKAY);
      n++;
    end
    chk(d, 32'h0);
    chk({31'h0, int_pin_oe}, 32'h1);
    // Power down with a nonzero resolution code, which must read back.
    wr(LSCI_OFF_CTRL, 32'h3 << LSCI_CTRL_RES_LSB, LSCI_RESP_OKAY);
    rd(LSCI_OFF_CTRL, LSCI_RESP_OKAY);
    chk(d, 32'h3 << LSCI_CTRL_RES_LSB);
    repeat (2000) @(posedge sys_clk);
    rd(LSCI_OFF_STAT, LSCI_RESP_OKAY);
    repeat (2000) @(posedge sys_clk);
    chk({31'h0, int_pin_oe}, 32'h0);
    rd(LSCI_OFF_STAT, LSCI_RESP_OKAY);
    chk(d & 32'h4, 32'h0);
    i_lsci_host_model.lag = 0;
    light_pulse <= 1'b1;
  endtask : t_continuous

  // Interrupt raised, masked and cleared; unmapped address refused.
  task automatic t_irq();
    for (int m = 1; m >= 0; m--) begin
      // Clear events left by earlier runs so the next one is fresh.
      rd(LSCI_OFF_IRQ_STAT, LSCI_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      wr(LSCI_OFF_IRQ_MASK, m, LSCI_RESP_OKAY);
      wr(LSCI_OFF_CTRL, cw(2'b01, LSCI_LUX_SCALE_HIGHEST, 1'b1),
         LSCI_RESP_OKAY);
      wait_oe(1'b1);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, irq}, m);
      rd(LSCI_OFF_IRQ_STAT, LSCI_RESP_OKAY);
      chk(d & 32'h1, 32'h1);
      @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      rd(LSCI_OFF_STAT, LSCI_RESP_OKAY);
    end
    wr(8'h20, 32'hffff_ffff, LSCI_RESP_SLVERR);
    rd(8'h20, LSCI_RESP_SLVERR);
    chk(d, 32'h0);
    // The refused write leaves its own sticky event bit.
    rd(LSCI_OFF_IRQ_STAT, LSCI_RESP_OKAY);
    chk(d & 32'h2, 32'h2);
  endtask : t_irq

  // Main sequence: reset for four cycles, then every scenario.
  initial begin
    errors = 0;
    compares = 0;
    resetn = 1'b0;
    light_pulse = 1'b1;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_one_shot();
    t_scales();
    t_continuous();
    t_irq();
    end_sim();
  end
endmodule : lsci_top_tb
`default_nettype wire

// ==== rtl/lsci_adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Charge-balancing accumulator: counts light pulses and scales by range.
module lsci_adc_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Front end.
  input wire logic light_pulse,
  input wire logic clear,
  input wire logic [1:0] range_sel,
  // Result.
  output logic [15:0] count
);
  import lsci_pkg::*;

  // Wide accumulator keeps headroom before the range shift.
  typedef struct packed {
    logic [23:0] acc;
  } lsci_acc_t;

  lsci_acc_t s_q;
  lsci_acc_t s_d;
  logic [23:0] scaled;

  // Accumulate pulses; clear restarts a new conversion.
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.acc = '0;
    end else if (light_pulse && s_q.acc != 24'hff_ffff) begin
      s_d.acc = s_q.acc + 24'h00_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Counts per lux scale
  // Each wider range gives a quarter of the counts per lux; saturate.
  always_comb begin
    scaled = s_q.acc >> {range_sel, 1'b0};
    if (scaled > 24'h00_ffff) begin
      count = 16'hffff;
    end else begin
      count = scaled[LSCI_RES_W-1:0];
    end
  end

endmodule : lsci_adc_model
`default_nettype wire

// ==== rtl/lsci_conv_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Conversion timer: counts one conversion period, shortened by resolution.
module lsci_conv_timer (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Control.
  input wire logic start,
  input wire logic [1:0] res_sel,
  input wire logic [31:0] full_cyc,
  // Status.
  output logic busy,
  output logic done
);
  import lsci_pkg::*;

  // All timer state in one struct.
  typedef struct packed {
    logic busy;
    logic done;
    logic [31:0] cnt;
  } lsci_tmr_t;

  lsci_tmr_t s_q;
  lsci_tmr_t s_d;

  // Period per resolution
  // Each resolution step divides the period by 16, never below the floor.
  function automatic logic [31:0] lsci_period(input logic [31:0] full,
                                              input logic [1:0] res);
    logic [31:0] p;
    p = full >> {res, 2'b00};
    if (p < 32'(LSCI_CONV_MIN_CYC)) begin
      p = 32'(LSCI_CONV_MIN_CYC);
    end
    return p;
  endfunction : lsci_period

  // Next-state logic; done pulses for one cycle at the end of a period.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (s_q.busy) begin
      if (s_q.cnt <= 32'h0000_0001) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 32'h0000_0001;
      end
    end else if (start) begin
      s_d.busy = 1'b1;
      s_d.cnt = lsci_period(full_cyc, res_sel);
    end
  end

  // State register.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;

endmodule : lsci_conv_timer
`default_nettype wire

// ==== rtl/lsci_pkg.sv ====
package lsci_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] LSCI_OFF_CTRL = 8'h00;
  localparam logic [7:0] LSCI_OFF_STAT = 8'h04;
  localparam logic [7:0] LSCI_OFF_DATA = 8'h08;
  localparam logic [7:0] LSCI_OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] LSCI_OFF_IRQ_MASK = 8'h10;

  // Control register field positions.
  localparam int LSCI_CTRL_MODE_LSB = 0;
  localparam int LSCI_CTRL_RANGE_LSB = 2;
  localparam int LSCI_CTRL_RES_LSB = 4;
  localparam int LSCI_CTRL_START_BIT = 6;

  // Reset value of the control register: software power-down, lowest range.
  localparam logic [31:0] LSCI_CTRL_RST = 32'h0000_0000;

  // Result width.
  localparam int LSCI_RES_W = 16;

  // Conversion timing: printed figures and derived cycle counts.
  localparam int LSCI_CLK_MHZ = 125;
  localparam int LSCI_TCONV_FULL_MS = 90;
  localparam int LSCI_TCONV_MIN_NS = 11000;
  localparam int LSCI_CONV_FULL_CYC = LSCI_TCONV_FULL_MS * 1000 * LSCI_CLK_MHZ;
  localparam int LSCI_CONV_MIN_CYC = (LSCI_TCONV_MIN_NS * LSCI_CLK_MHZ) / 1000;

  // Operating modes.
  typedef enum logic [1:0] {
    LSCI_MODE_SW_DOWN = 2'b00,
    LSCI_MODE_ONE_SHOT = 2'b01,
    LSCI_MODE_CONTINUOUS = 2'b10,
    LSCI_MODE_RSVD = 2'b11
  } lsci_mode_t;

  // Lux scales.
  typedef enum logic [1:0] {
    LSCI_LUX_SCALE_LOWEST = 2'b00,
    LSCI_LUX_SCALE_LOW = 2'b01,
    LSCI_LUX_SCALE_HIGH = 2'b10,
    LSCI_LUX_SCALE_HIGHEST = 2'b11
  } lsci_range_t;

  // AXI responses.
  localparam logic [1:0] LSCI_RESP_OKAY = 2'b00;
  localparam logic [1:0] LSCI_RESP_SLVERR = 2'b10;

endpackage : lsci_pkg

// ==== rtl/lsci_top.sv ====
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Results are unsigned, up to sixteen bits.
// - Period 90 ms full, down to 11 us.
// - One-shot mode powers down after conversion.
// - Software power-down set and left by host.
// - Interrupt flag persists until host clears.
// - Conversions continue while interrupt pending.
// - Interrupt pin open-drain, pulled low only.
// - Four lux scales set counts per lux.
module lsci_top #(
  parameter int CONV_FULL_CYC = lsci_pkg::LSCI_CONV_FULL_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Light front end.
  input wire logic light_pulse,
  // Open-drain interrupt pin and level interrupt.
  output logic int_pin_o,
  output logic int_pin_oe,
  output logic irq
);
  import lsci_pkg::*;

  // All block state in one struct.
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] range;
    logic [1:0] res;
    logic start_req;
    logic [15:0] result;
    logic conv_flag;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lsci_state_t;

  lsci_state_t s_q;
  lsci_state_t s_d;

  // Timer and converter hookup.
  logic tmr_busy;
  logic tmr_done;
  logic tmr_start;
  logic [15:0] adc_count;
  logic wr_fire;
  logic rd_fire;

  // Write merges byte lanes into a register value.
  function automatic logic [31:0] lsci_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : lsci_merge

  // Control word packed from its fields.
  function automatic logic [31:0] lsci_ctrl_word(input lsci_state_t s);
    logic [31:0] w;
    w = LSCI_CTRL_RST;
    w[LSCI_CTRL_MODE_LSB +: 2] = s.mode;
    w[LSCI_CTRL_RANGE_LSB +: 2] = s.range;
    w[LSCI_CTRL_RES_LSB +: 2] = s.res;
    return w;
  endfunction : lsci_ctrl_word

  // Conversion timer instance; the resolution field shortens the period.
  // Conversion period timer
  lsci_conv_timer i_lsci_conv_timer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(tmr_start),
    .res_sel(s_q.res),
    .full_cyc(32'(CONV_FULL_CYC)),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // Converter accumulator, restarted with each new conversion.
  lsci_adc_model i_lsci_adc_model (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .light_pulse(light_pulse),
    .clear(tmr_start),
    .range_sel(s_q.range),
    .count(adc_count)
  );

  // Continuous mode starts back to back even with irq pending; software
  // power-down never starts, one-shot starts only on request.
  // Continuous back-to-back
  always_comb begin
    tmr_start = 1'b0;
    if (!tmr_busy && !tmr_done) begin
      if (s_q.mode == LSCI_MODE_CONTINUOUS) begin
        tmr_start = 1'b1;
      end else if (s_q.mode == LSCI_MODE_ONE_SHOT && s_q.start_req) begin
        tmr_start = 1'b1;
      end
    end
  end

  // A write fires once both address and data are held and no response waits.
  assign wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
  assign rd_fire = s_axi_arvalid && !s_q.rvalid;

  assign s_axi_awready = !s_q.aw_hold;
  assign s_axi_wready = !s_q.w_hold;
  assign s_axi_arready = !s_q.rvalid;

  // Main next-state process.
  always_comb begin
    logic [31:0] nv;
    nv = '0;
    s_d = s_q;

    // Catch address and data independently, in either order.
    if (s_axi_awvalid && !s_q.aw_hold) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_hold) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // One-shot request is consumed when its conversion begins.
    if (tmr_start) begin
      s_d.start_req = 1'b0;
    end

    // Register writes.
    // Register write decode
    if (wr_fire) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = LSCI_RESP_OKAY;
      if (s_q.aw_addr == LSCI_OFF_CTRL) begin
        nv = lsci_merge(lsci_ctrl_word(s_q), s_q.w_data, s_q.w_strb);
        s_d.mode = nv[LSCI_CTRL_MODE_LSB +: 2];
        s_d.range = nv[LSCI_CTRL_RANGE_LSB +: 2];
        s_d.res = nv[LSCI_CTRL_RES_LSB +: 2];
        s_d.start_req = nv[LSCI_CTRL_START_BIT] && s_q.w_strb[0];
      end else if (s_q.aw_addr == LSCI_OFF_IRQ_MASK) begin
        nv = lsci_merge({30'h0, s_q.irq_mask}, s_q.w_data, s_q.w_strb);
        s_d.irq_mask = nv[1:0];
      end else if (s_q.aw_addr == LSCI_OFF_STAT ||
                   s_q.aw_addr == LSCI_OFF_DATA ||
                   s_q.aw_addr == LSCI_OFF_IRQ_STAT) begin
        s_d.bresp = LSCI_RESP_OKAY;
      end else begin
        s_d.bresp = LSCI_RESP_SLVERR;
      end
    end

    // Register reads; a status read clears the flag, an interrupt status read the sticky bits.
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = LSCI_RESP_OKAY;
      if (s_axi_araddr == LSCI_OFF_CTRL) begin
        s_d.rdata = lsci_ctrl_word(s_q);
      end else if (s_axi_araddr == LSCI_OFF_STAT) begin
        s_d.rdata = {28'h0, s_q.start_req, tmr_busy, 1'b0, s_q.conv_flag};
        s_d.conv_flag = 1'b0;
      end else if (s_axi_araddr == LSCI_OFF_DATA) begin
        s_d.rdata = {16'h0, s_q.result};
      end else if (s_axi_araddr == LSCI_OFF_IRQ_STAT) begin
        s_d.rdata = {30'h0, s_q.irq_stat};
        s_d.irq_stat = 2'b00;
      end else if (s_axi_araddr == LSCI_OFF_IRQ_MASK) begin
        s_d.rdata = {30'h0, s_q.irq_mask};
      end else begin
        s_d.rdata = '0;
        s_d.rresp = LSCI_RESP_SLVERR;
      end
    end

    // Conversion end: latch result and set flags; the set beats a clear.
    // Latch 16-bit result
    if (tmr_done) begin
      s_d.result = adc_count;
      s_d.conv_flag = 1'b1;
      s_d.irq_stat[0] = 1'b1;
    end
    // A write that the bus refused is an event too.
    if (wr_fire && s_d.bresp == LSCI_RESP_SLVERR) begin
      s_d.irq_stat[1] = 1'b1;
    end
  end

  // State register.
  // Reset clears flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus outputs straight from flops.
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // The pin is only ever pulled low, never driven high.
  // Open-drain drive
  assign int_pin_o = 1'b0;
  assign int_pin_oe = s_q.conv_flag;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);

  // Assertions guarding the block.
  AST_PIN_FOLLOWS_FLAG: assert property (
    @(posedge sys_clk) disable iff (!resetn) int_pin_oe == s_q.conv_flag)
    else $error("Interrupt pin does not follow the flag.");

  AST_PIN_NEVER_HIGH: assert property (
    @(posedge sys_clk) disable iff (!resetn) int_pin_o == 1'b0)
    else $error("Interrupt pin driven high.");

  AST_FLAG_ON_DONE: assert property (
    @(posedge sys_clk) disable iff (!resetn) tmr_done |=> s_q.conv_flag)
    else $error("Flag not set after conversion end.");

  AST_FLAG_HOLDS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (s_q.conv_flag && !(rd_fire && s_axi_araddr == LSCI_OFF_STAT))
    |=> s_q.conv_flag)
    else $error("Flag dropped without a status read.");

  AST_CONT_RESTART: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (tmr_done && s_q.mode == LSCI_MODE_CONTINUOUS && !wr_fire)
    |=> ##1 tmr_busy)
    else $error("Continuous conversion did not restart.");

  AST_ONESHOT_STOPS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (s_q.mode == LSCI_MODE_ONE_SHOT && !s_q.start_req) |-> !tmr_start)
    else $error("One-shot started without a request.");

  AST_SWDOWN_IDLE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    s_q.mode == LSCI_MODE_SW_DOWN |-> !tmr_start)
    else $error("Conversion started in software power-down.");

  AST_RESULT_LATCH: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    tmr_done |=> s_q.result == $past(adc_count))
    else $error("Result not latched at conversion end.");

  AST_RANGE_WRITE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (wr_fire && s_q.aw_addr == LSCI_OFF_CTRL && s_q.w_strb[0])
    |=> s_q.range == $past(s_q.w_data[LSCI_CTRL_RANGE_LSB +: 2]))
    else $error("Range write not taken.");

  AST_BRESP_ONE: assert property (
    @(posedge sys_clk) disable iff (!resetn) wr_fire |=> s_axi_bvalid)
    else $error("Write response missing.");

  AST_IRQ_STAT_SET: assert property (
    @(posedge sys_clk) disable iff (!resetn) tmr_done |=> s_q.irq_stat[0])
    else $error("Conversion end not recorded as an event.");

  AST_IRQ_STICKY: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (s_q.irq_stat[0] && !(rd_fire && s_axi_araddr == LSCI_OFF_IRQ_STAT))
    |=> s_q.irq_stat[0])
    else $error("Event bit dropped without a read.");

  AST_RESULT_STEADY: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !tmr_done |=> $stable(s_q.result))
    else $error("Result changed without a conversion end.");

  AST_PIN_RELEASE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (rd_fire && s_axi_araddr == LSCI_OFF_STAT && !tmr_done)
    |=> !int_pin_oe)
    else $error("Interrupt pin not released after a status read.");

  AST_BRESP_STANDS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (s_axi_bvalid && !s_axi_bready)
    |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("Write response dropped before it was taken.");

  AST_RDATA_STANDS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (s_axi_rvalid && !s_axi_rready)
    |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("Read data dropped before it was taken.");

endmodule : lsci_top
`default_nettype wire
